// ==== fgd_pkg.sv ====
// Function
// - concurrent-region programming keeps fetches and loads from the stall region running
// - stall-region programming halts the CPU until the operation completes
// - concurrent region unreadable from the start of any loader erase or write until the re-enable command
// - halt or concurrent read chosen by the programmed page address region
// - loader region always lies wholly inside the stall region
// - concurrent-region busy flag reads one while concurrent region is blocked
// - two independent lock pairs: application region and loader region
// - lock bits only programmed by software or pins; chip erase restores them
// - general memory lock modes never gate store or load here
// - app lock 11 free; 10 blocks stores into application region
// - app lock 00 blocks stores and loader-side loads of application region
// - app lock 01 allows stores, blocks loader-side loads of application region
// - app lock 00/01, vectors in loader: irqs suppressed in application region
// - loader lock 11 free; 10 blocks stores into loader region
// - loader lock 00 blocks stores and application-side loads of loader region
// - loader lock 01 allows stores, blocks application-side loads of loader region
// - loader lock 00/01, vectors in application: irqs suppressed in loader region
// - store starts programming only when executed from the loader region
`default_nettype none
package fgd_pkg;
	localparam int             FGD_AW         = 14;
	localparam int             FGD_PW         = 8;
	localparam logic [13:0]    FGD_STALL_BASE = 14'h3800;
	localparam logic [13:0]    FGD_LDR_B256   = 14'h3f00;
	localparam logic [13:0]    FGD_LDR_B512   = 14'h3e00;
	localparam logic [13:0]    FGD_LDR_B1K    = 14'h3c00;
	localparam logic [13:0]    FGD_LDR_B2K    = 14'h3800;

	localparam logic [7:0]     FGD_OFS_CTRL   = 8'h00;
	localparam logic [7:0]     FGD_OFS_LOCK   = 8'h04;
	localparam logic [7:0]     FGD_OFS_CFG    = 8'h08;
	localparam logic [7:0]     FGD_OFS_STAT   = 8'h0c;

	localparam int             FGD_B_SPMEN    = 0;
	localparam int             FGD_B_BUSY     = 6;
	localparam logic [4:0]     FGD_CMD_FILL   = 5'h01;
	localparam logic [4:0]     FGD_CMD_ERASE  = 5'h03;
	localparam logic [4:0]     FGD_CMD_WRITE  = 5'h05;
	localparam logic [4:0]     FGD_CMD_LOCK   = 5'h09;
	localparam logic [4:0]     FGD_CMD_REEN   = 5'h11;

	localparam int             FGD_L_APP_HI   = 3;
	localparam int             FGD_L_APP_LO   = 2;
	localparam int             FGD_L_LDR_HI   = 1;
	localparam int             FGD_L_LDR_LO   = 0;
	localparam logic [3:0]     FGD_LOCK_ERASED = 4'hf;
	localparam logic [1:0]     FGD_SIZE_RESET = 2'h0;
	localparam logic           FGD_VEC_RESET  = 1'b0;
	localparam int             FGD_CFG_VEC    = 2;
	localparam int             FGD_ST_SBLK    = 0;
	localparam int             FGD_ST_LBLK    = 1;
	localparam int             FGD_ST_HALT    = 2;
	localparam int             FGD_ST_OP      = 3;

	localparam logic [2:0]     FGD_SPM_WINDOW = 3'h4;

	typedef enum logic [1:0] {
		FGD_IDLE  = 2'b00,
		FGD_ARMED = 2'b01,
		FGD_BUSY  = 2'b11
	} fgd_state_t;

	function automatic logic [13:0] fgd_loader_base(input logic [1:0] sz);
		logic [13:0] b;
		b = FGD_LDR_B2K;
		case (sz)
			2'h3: b = FGD_LDR_B256;
			2'h2: b = FGD_LDR_B512;
			2'h1: b = FGD_LDR_B1K;
			default: b = FGD_LDR_B2K;
		endcase
		// never let the loader reach below the stall boundary
		if (b < FGD_STALL_BASE) begin
			b = FGD_STALL_BASE;
		end
		return b;
	endfunction
endpackage
`default_nettype wire

// ==== fgd_region_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module fgd_region_map (
	input  wire logic [13:0] addr,
	input  wire logic [13:0] loader_base,
	output logic             in_concurrent,
	output logic             in_loader
);
	always_comb begin
		in_concurrent = addr < fgd_pkg::FGD_STALL_BASE;
		in_loader     = addr >= loader_base;
	end
endmodule
`default_nettype wire

// ==== fgd_lock_eval.sv ====
`timescale 1ns/1ps
`default_nettype none
module fgd_lock_eval (
	input  wire logic [3:0] lock,
	input  wire logic       pc_in_loader,
	input  wire logic       tgt_in_loader,
	input  wire logic       vec_in_loader,
	output logic            store_ok,
	output logic            load_ok,
	output logic            irq_block
);
	logic app_hi;
	logic app_lo;
	logic ldr_hi;
	logic ldr_lo;

	always_comb begin
		app_hi = lock[fgd_pkg::FGD_L_APP_HI];
		app_lo = lock[fgd_pkg::FGD_L_APP_LO];
		ldr_hi = lock[fgd_pkg::FGD_L_LDR_HI];
		ldr_lo = lock[fgd_pkg::FGD_L_LDR_LO];
		// a clear low bit forbids stores into its region
		store_ok = tgt_in_loader ? ldr_lo : app_lo;
		// a clear high bit forbids loads from the other region
		if (pc_in_loader == tgt_in_loader) begin
			load_ok = 1'b1;
		end else if (pc_in_loader) begin
			load_ok = app_hi;
		end else begin
			load_ok = ldr_hi;
		end
		if (vec_in_loader) begin
			irq_block = !pc_in_loader && !app_hi;
		end else begin
			irq_block = pc_in_loader && !ldr_hi;
		end
	end
endmodule
`default_nettype wire

// ==== fgd_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
module fgd_guard (
	input  wire logic        mclk,
	input  wire logic        resetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// cpu core, same clock
	input  wire logic [13:0] cpu_pc,
	input  wire logic        spm_exec,
	input  wire logic [13:0] spm_addr,
	input  wire logic [3:0]  spm_data,
	input  wire logic        lpm_req,
	input  wire logic [13:0] lpm_addr,
	output logic             lpm_grant,
	output logic             lpm_deny,
	output logic             cpu_halt,
	output logic             concurrent_blocked,
	output logic             irq_suppress,
	// flash array, same clock
	input  wire logic        flash_done,
	output logic             flash_erase,
	output logic             flash_write,
	output logic [13:0]      flash_page,
	// programming pins, asynchronous
	input  wire logic        chip_erase_pin,
	input  wire logic        ext_lock_strobe,
	input  wire logic [3:0]  ext_lock_val
);
	fgd_pkg::fgd_state_t state_ff;
	fgd_pkg::fgd_state_t nxt_state;
	logic [4:0]          cmd_ff;
	logic [4:0]          nxt_cmd;
	logic [2:0]          win_ff;
	logic [2:0]          nxt_win;
	logic                busy_ff;
	logic                nxt_busy;
	logic                halt_ff;
	logic                nxt_halt;
	logic [13:0]         page_ff;
	logic [13:0]         nxt_page;
	logic                erase_ff;
	logic                nxt_erase;
	logic                write_ff;
	logic                nxt_write;
	logic [3:0]          lock_ff;
	logic [3:0]          nxt_lock;
	logic [1:0]          size_ff;
	logic [1:0]          nxt_size;
	logic                vec_ff;
	logic                nxt_vec;
	logic [1:0]          blk_ff;
	logic [1:0]          nxt_blk;
	logic                grant_ff;
	logic                nxt_grant;
	logic                deny_ff;
	logic                nxt_deny;
	logic                irqb_ff;
	logic                nxt_irqb;
	logic                pready_ff;
	logic                nxt_pready;
	logic [31:0]         prdata_ff;
	logic [31:0]         nxt_prdata;
	logic                pslverr_ff;
	logic                nxt_pslverr;
	logic [2:0]          ce_sync_ff;
	logic [2:0]          ls_sync_ff;
	logic [3:0]          lv_meta_ff;
	logic [3:0]          lv_sync_ff;

	logic [13:0]         ldr_base;
	logic                pc_ldr;
	logic                spm_conc;
	logic                spm_ldr;
	logic                lpm_conc;
	logic                lpm_ldr;
	logic                spm_store_ok;
	logic                lpm_load_ok;
	logic                irq_blk;
	logic                wr_hit;
	logic                rd_phase;
	logic                ce_pulse;
	logic                ls_pulse;

	always_comb begin
		ldr_base = fgd_pkg::fgd_loader_base(size_ff);
	end

	fgd_region_map u_map_pc (
		.addr          (cpu_pc),
		.loader_base   (ldr_base),
		.in_concurrent (),
		.in_loader     (pc_ldr)
	);

	fgd_region_map u_map_spm (
		.addr          (spm_addr),
		.loader_base   (ldr_base),
		.in_concurrent (spm_conc),
		.in_loader     (spm_ldr)
	);

	fgd_region_map u_map_lpm (
		.addr          (lpm_addr),
		.loader_base   (ldr_base),
		.in_concurrent (lpm_conc),
		.in_loader     (lpm_ldr)
	);

	fgd_lock_eval u_lock_spm (
		.lock          (lock_ff),
		.pc_in_loader  (pc_ldr),
		.tgt_in_loader (spm_ldr),
		.vec_in_loader (vec_ff),
		.store_ok      (spm_store_ok),
		.load_ok       (),
		.irq_block     (irq_blk)
	);

	fgd_lock_eval u_lock_lpm (
		.lock          (lock_ff),
		.pc_in_loader  (pc_ldr),
		.tgt_in_loader (lpm_ldr),
		.vec_in_loader (vec_ff),
		.store_ok      (),
		.load_ok       (lpm_load_ok),
		.irq_block     ()
	);

	// pins are asynchronous: two stages before any logic looks
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ce_sync_ff <= 3'h0;
			ls_sync_ff <= 3'h0;
			lv_meta_ff <= fgd_pkg::FGD_LOCK_ERASED;
			lv_sync_ff <= fgd_pkg::FGD_LOCK_ERASED;
		end else begin
			ce_sync_ff <= {ce_sync_ff[1:0], chip_erase_pin};
			ls_sync_ff <= {ls_sync_ff[1:0], ext_lock_strobe};
			lv_meta_ff <= ext_lock_val;
			lv_sync_ff <= lv_meta_ff;
		end
	end

	always_comb begin
		ce_pulse = ce_sync_ff[1] && !ce_sync_ff[2];
		ls_pulse = ls_sync_ff[1] && !ls_sync_ff[2];
		wr_hit   = psel && penable && pready_ff && pwrite && pstrb[0];
		rd_phase = psel && penable && !pready_ff;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cmd   = cmd_ff;
		nxt_win   = win_ff;
		nxt_busy  = busy_ff;
		nxt_halt  = halt_ff;
		nxt_page  = page_ff;
		nxt_erase = 1'b0;
		nxt_write = 1'b0;
		nxt_lock  = lock_ff;
		nxt_size  = size_ff;
		nxt_vec   = vec_ff;
		nxt_blk   = blk_ff;
		nxt_grant = 1'b0;
		nxt_deny  = 1'b0;
		// general memory lock modes have no input here by design
		nxt_irqb  = irq_blk;
		case (state_ff)
			fgd_pkg::FGD_IDLE: begin
				if (wr_hit && paddr == fgd_pkg::FGD_OFS_CTRL) begin
					// only the documented five-bit patterns arm the store
					if (pwdata[4:0] == fgd_pkg::FGD_CMD_FILL ||
					    pwdata[4:0] == fgd_pkg::FGD_CMD_ERASE ||
					    pwdata[4:0] == fgd_pkg::FGD_CMD_WRITE ||
					    pwdata[4:0] == fgd_pkg::FGD_CMD_LOCK ||
					    pwdata[4:0] == fgd_pkg::FGD_CMD_REEN) begin
						nxt_cmd   = pwdata[4:0];
						nxt_win   = fgd_pkg::FGD_SPM_WINDOW;
						nxt_state = fgd_pkg::FGD_ARMED;
					end
				end
			end
			fgd_pkg::FGD_ARMED: begin
				if (spm_exec && pc_ldr) begin
					nxt_state = fgd_pkg::FGD_IDLE;
					nxt_cmd   = 5'h00;
					nxt_win   = 3'h0;
					if (cmd_ff == fgd_pkg::FGD_CMD_ERASE ||
					    cmd_ff == fgd_pkg::FGD_CMD_WRITE) begin
						if (spm_store_ok) begin
							nxt_state = fgd_pkg::FGD_BUSY;
							nxt_cmd   = cmd_ff;
							nxt_page  = spm_addr;
							nxt_erase = cmd_ff == fgd_pkg::FGD_CMD_ERASE;
							nxt_write = cmd_ff == fgd_pkg::FGD_CMD_WRITE;
							nxt_busy  = 1'b1;
							// decided by target page, not by where the cpu runs
							nxt_halt  = !spm_conc;
						end else begin
							nxt_blk[fgd_pkg::FGD_ST_SBLK] = 1'b1;
						end
					end else if (cmd_ff == fgd_pkg::FGD_CMD_LOCK) begin
						// and-in: software can only program lock bits
						nxt_lock = lock_ff & spm_data;
					end else if (cmd_ff == fgd_pkg::FGD_CMD_REEN) begin
						nxt_busy = 1'b0;
					end
				end else if (spm_exec) begin
					// store from application code is ignored outright
					nxt_state = fgd_pkg::FGD_IDLE;
					nxt_cmd   = 5'h00;
					nxt_win   = 3'h0;
				end else if (win_ff == 3'h1) begin
					nxt_state = fgd_pkg::FGD_IDLE;
					nxt_cmd   = 5'h00;
					nxt_win   = 3'h0;
				end else begin
					nxt_win = win_ff - 3'h1;
				end
			end
			fgd_pkg::FGD_BUSY: begin
				if (flash_done) begin
					nxt_state = fgd_pkg::FGD_IDLE;
					nxt_cmd   = 5'h00;
					nxt_halt  = 1'b0;
				end
			end
			default: begin
				nxt_state = fgd_pkg::FGD_IDLE;
			end
		endcase
		// loads: lock checks, and nothing from the concurrent region while busy
		if (lpm_req) begin
			if (!lpm_load_ok || (busy_ff && lpm_conc)) begin
				nxt_deny = 1'b1;
				nxt_blk[fgd_pkg::FGD_ST_LBLK] = 1'b1;
			end else begin
				nxt_grant = 1'b1;
			end
		end
		if (wr_hit && paddr == fgd_pkg::FGD_OFS_CFG) begin
			nxt_size = pwdata[1:0];
			nxt_vec  = pwdata[fgd_pkg::FGD_CFG_VEC];
		end
		// set wins over clear: only clear bits not being set this cycle
		if (wr_hit && paddr == fgd_pkg::FGD_OFS_STAT) begin
			nxt_blk = nxt_blk & ~(pwdata[1:0] & ~(nxt_blk & ~blk_ff));
		end
		if (ls_pulse) begin
			nxt_lock = nxt_lock & lv_sync_ff;
		end
		// chip erase and reset are the only ways back to unprogrammed
		if (ce_pulse) begin
			nxt_lock = fgd_pkg::FGD_LOCK_ERASED;
		end
	end

	always_comb begin
		nxt_pready  = rd_phase;
		nxt_prdata  = 32'h0;
		nxt_pslverr = 1'b0;
		if (rd_phase) begin
			if (paddr == fgd_pkg::FGD_OFS_CTRL) begin
				nxt_prdata[4:0] = cmd_ff;
				nxt_prdata[fgd_pkg::FGD_B_SPMEN] = state_ff != fgd_pkg::FGD_IDLE;
				nxt_prdata[fgd_pkg::FGD_B_BUSY]  = busy_ff;
			end else if (paddr == fgd_pkg::FGD_OFS_LOCK) begin
				nxt_prdata[3:0] = lock_ff;
			end else if (paddr == fgd_pkg::FGD_OFS_CFG) begin
				nxt_prdata[1:0] = size_ff;
				nxt_prdata[fgd_pkg::FGD_CFG_VEC] = vec_ff;
			end else if (paddr == fgd_pkg::FGD_OFS_STAT) begin
				nxt_prdata[1:0] = blk_ff;
				nxt_prdata[fgd_pkg::FGD_ST_HALT] = halt_ff;
				nxt_prdata[fgd_pkg::FGD_ST_OP]   = state_ff == fgd_pkg::FGD_BUSY;
			end else begin
				nxt_pslverr = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff   <= fgd_pkg::FGD_IDLE;
			cmd_ff     <= 5'h00;
			win_ff     <= 3'h0;
			busy_ff    <= 1'b0;
			halt_ff    <= 1'b0;
			page_ff    <= 14'h0000;
			erase_ff   <= 1'b0;
			write_ff   <= 1'b0;
			lock_ff    <= fgd_pkg::FGD_LOCK_ERASED;
			size_ff    <= fgd_pkg::FGD_SIZE_RESET;
			vec_ff     <= fgd_pkg::FGD_VEC_RESET;
			blk_ff     <= 2'h0;
			grant_ff   <= 1'b0;
			deny_ff    <= 1'b0;
			irqb_ff    <= 1'b0;
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0;
			pslverr_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cmd_ff     <= nxt_cmd;
			win_ff     <= nxt_win;
			busy_ff    <= nxt_busy;
			halt_ff    <= nxt_halt;
			page_ff    <= nxt_page;
			erase_ff   <= nxt_erase;
			write_ff   <= nxt_write;
			lock_ff    <= nxt_lock;
			size_ff    <= nxt_size;
			vec_ff     <= nxt_vec;
			blk_ff     <= nxt_blk;
			grant_ff   <= nxt_grant;
			deny_ff    <= nxt_deny;
			irqb_ff    <= nxt_irqb;
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	always_comb begin
		pready             = pready_ff;
		prdata             = prdata_ff;
		pslverr            = pslverr_ff;
		lpm_grant          = grant_ff;
		lpm_deny           = deny_ff;
		cpu_halt           = halt_ff;
		concurrent_blocked = busy_ff;
		irq_suppress       = irqb_ff;
		flash_erase        = erase_ff;
		flash_write        = write_ff;
		flash_page         = page_ff;
	end
endmodule
`default_nettype wire

// ==== fgd_guard_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fgd_guard_chk (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        lpm_req,
	input wire logic [13:0] lpm_addr,
	input wire logic        lpm_grant,
	input wire logic        lpm_deny,
	input wire logic        cpu_halt,
	input wire logic        concurrent_blocked,
	input wire logic        flash_done,
	input wire logic        flash_erase,
	input wire logic        flash_write,
	input wire logic [13:0] flash_page
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_op;
		flash_erase || flash_write;
	endsequence
	apb_one_wait_a: assert property (s_wait |=> pready)
		else $error("pready not after one wait");
	apb_err_pair_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	op_pulse_a: assert property (s_op |=> !flash_erase && !flash_write)
		else $error("op strobe longer than one cycle");
	op_busy_flag_a: assert property (s_op |-> concurrent_blocked)
		else $error("busy flag low at op start");
	conc_no_halt_a: assert property (s_op ##0 (flash_page < fgd_pkg::FGD_STALL_BASE)
		|-> !cpu_halt)
		else $error("halt on concurrent page");
	stall_halt_a: assert property (s_op ##0 (flash_page >= fgd_pkg::FGD_STALL_BASE)
		|-> cpu_halt)
		else $error("no halt on stall page");
	halt_hold_a: assert property (cpu_halt && !flash_done && !$past(flash_done)
		|=> cpu_halt)
		else $error("halt dropped early");
	halt_release_a: assert property (cpu_halt && flash_done |-> ##[1:2] !cpu_halt)
		else $error("halt stuck after done");
	blocked_load_a: assert property (lpm_req && concurrent_blocked
		&& lpm_addr < fgd_pkg::FGD_STALL_BASE |=> lpm_deny)
		else $error("load of busy region granted");
	load_answer_a: assert property (lpm_req |=> lpm_grant != lpm_deny)
		else $error("load answer not one-hot");
	page_latched_a: assert property (!$stable(flash_page) |-> s_op)
		else $error("page moved outside op start");
endmodule
`default_nettype wire

// ==== fgd_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fgd_flash_model (
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       flash_erase,
	input  wire logic       flash_write,
	input  wire logic [7:0] dly,
	output logic            flash_done
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	// dly sets prompt or slow completion
	always_comb begin
		nxt_cnt = cnt_ff;
		if (flash_erase || flash_write) begin
			nxt_cnt = dly;
		end else if (cnt_ff != 8'h00) begin
			nxt_cnt = cnt_ff - 8'h01;
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
	assign flash_done = (cnt_ff == 8'h01);
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [13:0] LDR = 14'h3f00;
	localparam logic [13:0] APP = 14'h0100;
	logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic        spm_exec, lpm_req, lpm_grant, lpm_deny, cpu_halt, irq_suppress;
	logic        concurrent_blocked, flash_done, flash_erase, flash_write;
	logic        chip_erase_pin, ext_lock_strobe;
	logic [1:0]  p;
	logic [7:0]  paddr, flash_dly;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, spm_data, ext_lock_val;
	logic [13:0] cpu_pc, spm_addr, lpm_addr, flash_page;
	int          failures, checks_done;

	fgd_guard dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .cpu_pc(cpu_pc), .spm_exec(spm_exec),
		.spm_addr(spm_addr), .spm_data(spm_data), .lpm_req(lpm_req), .lpm_addr(lpm_addr),
		.lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .cpu_halt(cpu_halt),
		.concurrent_blocked(concurrent_blocked), .irq_suppress(irq_suppress),
		.flash_done(flash_done), .flash_erase(flash_erase), .flash_write(flash_write),
		.flash_page(flash_page), .chip_erase_pin(chip_erase_pin),
		.ext_lock_strobe(ext_lock_strobe), .ext_lock_val(ext_lock_val));
	fgd_flash_model u_flash (.mclk(mclk), .resetn(resetn), .flash_erase(flash_erase),
		.flash_write(flash_write), .dly(flash_dly), .flash_done(flash_done));

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers counts against the run
		if (pready !== 1'b1) begin
			failures++;
			$display("ERROR pready exp 1 got %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// store lands one edge after the command write, inside the arm window
	task automatic prog(input logic [4:0] c, input logic [13:0] pc, input logic [13:0] a,
		input logic [3:0] v);
		apb(1'b1, 8'h00, {27'h0, c});
		cpu_pc <= pc;
		spm_addr <= a;
		spm_data <= v;
		spm_exec <= 1'b1;
		@(posedge mclk);
		spm_exec <= 1'b0;
		spm_addr <= ~a;
		#1;
	endtask
	task automatic lpm(input logic [13:0] pc, input logic [13:0] a, input logic g);
		@(posedge mclk);
		cpu_pc <= pc;
		lpm_addr <= a;
		lpm_req <= 1'b1;
		@(posedge mclk);
		lpm_req <= 1'b0;
		#1;
		chk1("grant", g, lpm_grant);
		chk1("deny", !g, lpm_deny);
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (flash_done !== 1'b1 && n < 200);
		chk1("done", 1'b1, flash_done);
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// software must drop the busy flag before touching the lower region
	task automatic reen();
		prog(5'h11, LDR, 14'h0, 4'h0);
		chk1("busy", 1'b0, concurrent_blocked);
	endtask
	task automatic set_lock(input logic [3:0] v);
		@(posedge mclk);
		chip_erase_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		chip_erase_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		prog(5'h09, LDR, 14'h0, v);
		apb(1'b0, 8'h04, 32'h0);
		chk("lock", {28'h0, v}, rd);
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#500000;
		failures++;
		finish_test();
	end
	initial begin
		{resetn, psel, penable, pwrite, spm_exec, lpm_req} = 6'h0;
		{chip_erase_pin, ext_lock_strobe, paddr, pwdata} = 42'h0;
		{cpu_pc, spm_addr, lpm_addr, spm_data, ext_lock_val} = 50'h0;
		pstrb = 4'hf;
		flash_dly = 8'd30;
		failures = 0;
		checks_done = 0;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk("lock", 32'hf, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk1("slverr", 1'b1, err);
		chk("unmapped", 32'h0, rd);
		prog(5'h03, 14'h3800, APP, 4'h0);
		chk1("erase", 1'b1, flash_erase);
		chk1("halt", 1'b0, cpu_halt);
		chk1("busy", 1'b1, concurrent_blocked);
		chk("page", {18'h0, APP}, {18'h0, flash_page});
		lpm(LDR, 14'h3900, 1'b1);
		lpm(LDR, 14'h0200, 1'b0);
		wait_done();
		chk1("busy", 1'b1, concurrent_blocked);
		reen();
		flash_dly <= 8'd1;
		prog(5'h05, LDR, 14'h3a00, 4'h0);
		chk1("halt", 1'b1, cpu_halt);
		wait_done();
		chk1("halt", 1'b0, cpu_halt);
		reen();
		prog(5'h03, APP, APP, 4'h0);
		chk1("erase", 1'b0, flash_erase);
		repeat (6) @(posedge mclk);
		ext_lock_val <= 4'h7;
		repeat (4) @(posedge mclk);
		ext_lock_strobe <= 1'b1;
		repeat (6) @(posedge mclk);
		ext_lock_strobe <= 1'b0;
		prog(5'h09, LDR, 14'h0, 4'hf);
		apb(1'b0, 8'h04, 32'h0);
		chk("lock", 32'h7, rd);
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 4; i++) begin
				p = i[1:0];
				apb(1'b1, 8'h08, j ? 32'h3 : 32'h7);
				set_lock(j ? {2'b11, p} : {p, 2'b11});
				lpm(j ? APP : LDR, j ? 14'h3f80 : 14'h0200, p[1]);
				@(posedge mclk);
				cpu_pc <= j ? LDR : APP;
				repeat (3) @(posedge mclk);
				#1;
				chk1("irq", !p[1], irq_suppress);
				prog(5'h05, LDR, j ? LDR : 14'h0200, 4'h0);
				chk1("store", p[0], flash_write);
				if (p[0]) begin
					wait_done();
					reen();
				end else begin
					apb(1'b0, 8'h0c, 32'h0);
					chk("stat", 32'h1, rd & 32'h1);
					apb(1'b1, 8'h0c, 32'h3);
				end
			end
		end
		finish_test();
	end
endmodule

bind fgd_guard fgd_guard_chk u_chk (.mclk(mclk), .resetn(resetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .lpm_req(lpm_req),
	.lpm_addr(lpm_addr), .lpm_grant(lpm_grant), .lpm_deny(lpm_deny), .cpu_halt(cpu_halt),
	.concurrent_blocked(concurrent_blocked), .flash_done(flash_done),
	.flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page));
`default_nettype wire
